// file: core/cfd_pkg.sv
package cfd_pkg;
    // ==========================================
    // Flag positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_OVERFLOW = 1;
    localparam int FLAG_ZERO = 2;
    localparam int FLAG_SIGN = 3;
    localparam logic [7:0] FLAGS_RESET = 8'h80;
    // ==========================================
    // Register offsets
    localparam logic [3:0] OFS_FLAGS = 4'h0;
    localparam logic [3:0] OFS_OPA = 4'h1;
    localparam logic [3:0] OFS_OPB = 4'h2;
    localparam logic [3:0] OFS_CMD = 4'h3;
    localparam logic [3:0] OFS_RESULT = 4'h4;
    localparam logic [3:0] OFS_ADDR = 4'h5;
    localparam logic [3:0] OFS_ALIGNED = 4'h6;
    localparam logic [3:0] OFS_MEMDATA = 4'h7;
    // ==========================================
    // Command fields: op in [3:0], size in [5:4], bit index in [8:6]
    localparam int CMD_OP_LSB = 0;
    localparam int CMD_SIZE_LSB = 4;
    localparam int CMD_BIT_LSB = 6;
    localparam int CMD_FETCH = 9;
    typedef enum logic [1:0] {
        SZ_BYTE = 2'b00,
        SZ_WORD = 2'b01,
        SZ_LONG = 2'b10,
        SZ_NIBBLE = 2'b11
    } cfd_size_t;
    typedef enum logic [3:0] {
        OP_ADD = 4'b0000,
        OP_SUB = 4'b0001,
        OP_SHL = 4'b0010,
        OP_SHR = 4'b0011,
        OP_ROTL = 4'b0100,
        OP_ROTR = 4'b0101,
        OP_BLD = 4'b0110,
        OP_BST = 4'b0111,
        OP_BAND = 4'b1000,
        OP_BOR = 4'b1001,
        OP_BXOR = 4'b1010,
        OP_DADD = 4'b1011,
        OP_DSUB = 4'b1100,
        OP_MOVE = 4'b1101,
        OP_BSET = 4'b1110,
        OP_BCLR = 4'b1111
    } cfd_op_t;
endpackage : cfd_pkg

// file: core/cfd_bcd_fix.sv
`timescale 1ns/1ps
// ==========================================
// Decimal adjust of two packed digits
module cfd_bcd_fix (
    input wire logic [7:0] value,
    input wire logic carry_in,
    input wire logic subtract,
    output logic [7:0] adjusted,
    output logic carry_out
);
    logic [3:0] hi;
    logic [3:0] lo;
    logic [7:0] corr;
    assign hi = value[7:4];
    assign lo = value[3:0];
    always_comb begin
        corr = 8'h00;
        carry_out = carry_in;
        if (subtract) begin
            if (lo > 4'h9) begin
                corr[3:0] = 4'h6;
            end
            if (carry_in) begin
                corr[7:4] = 4'h6;
            end
            adjusted = value - corr;
        end else begin
            if (lo > 4'h9) begin
                corr[3:0] = 4'h6;
            end
            if (carry_in || hi > 4'h9 || (hi == 4'h9 && lo > 4'h9)) begin
                corr[7:4] = 4'h6;
                carry_out = 1'b1;
            end
            adjusted = value + corr;
        end
    end
endmodule : cfd_bcd_fix

// file: core/cfd_align.sv
`timescale 1ns/1ps
// ==========================================
// Even address forcing and big endian lanes
module cfd_align (
    input wire logic [23:0] addr,
    input wire logic wide,
    input wire logic [31:0] data,
    input wire logic [1:0] lane,
    output logic [23:0] aligned,
    output logic [7:0] lane_byte
);
    always_comb begin
        aligned = addr;
        if (wide) begin
            aligned[0] = 1'b0;
        end
        unique case (lane)
            2'b00: lane_byte = data[31:24];
            2'b01: lane_byte = data[23:16];
            2'b10: lane_byte = data[15:8];
            2'b11: lane_byte = data[7:0];
        endcase
    end
endmodule : cfd_align

// file: core/cfd_core.sv
`timescale 1ns/1ps
module cfd_core (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA
);
    logic [7:0] flags;
    logic [31:0] opa;
    logic [31:0] opb;
    logic [31:0] result;
    logic [23:0] addr;
    logic [31:0] next_result;
    logic [7:0] next_flags;
    logic [32:0] sum;
    logic [7:0] bcd_val;
    logic bcd_c;
    logic [23:0] aligned;
    logic [7:0] lane_byte;
    logic [31:0] mask;
    logic [31:0] sign_mask;
    logic cmd_go;
    cfd_pkg::cfd_op_t op;
    cfd_pkg::cfd_size_t sz;
    logic [2:0] bitn;
    logic acc_bit;
    logic sa;
    logic sb;
    logic sr;
    logic is_fetch;

    // ==========================================
    // Command decode
    assign cmd_go = REG_WR && REG_ADDR == cfd_pkg::OFS_CMD;
    assign op = cfd_pkg::cfd_op_t'(REG_WDATA[cfd_pkg::CMD_OP_LSB +: 4]);
    assign sz = cfd_pkg::cfd_size_t'(REG_WDATA[cfd_pkg::CMD_SIZE_LSB +: 2]);
    assign bitn = REG_WDATA[cfd_pkg::CMD_BIT_LSB +: 3];
    assign is_fetch = REG_WDATA[cfd_pkg::CMD_FETCH];
    assign acc_bit = flags[cfd_pkg::FLAG_CARRY];

    function automatic logic [31:0] size_mask(input cfd_pkg::cfd_size_t s);
        unique case (s)
            cfd_pkg::SZ_BYTE: size_mask = 32'h0000_00ff;
            cfd_pkg::SZ_WORD: size_mask = 32'h0000_ffff;
            cfd_pkg::SZ_LONG: size_mask = 32'hffff_ffff;
            cfd_pkg::SZ_NIBBLE: size_mask = 32'h0000_000f;
        endcase
    endfunction : size_mask

    function automatic logic [31:0] top_bit(input cfd_pkg::cfd_size_t s);
        unique case (s)
            cfd_pkg::SZ_BYTE: top_bit = 32'h0000_0080;
            cfd_pkg::SZ_WORD: top_bit = 32'h0000_8000;
            cfd_pkg::SZ_LONG: top_bit = 32'h8000_0000;
            cfd_pkg::SZ_NIBBLE: top_bit = 32'h0000_0008;
        endcase
    endfunction : top_bit

    assign mask = size_mask(sz);
    assign sign_mask = top_bit(sz);

    cfd_bcd_fix u_bcd (
        .value(opa[7:0]),
        .carry_in(acc_bit),
        .subtract(op == cfd_pkg::OP_DSUB),
        .adjusted(bcd_val),
        .carry_out(bcd_c)
    );

    cfd_align u_align (
        .addr(REG_WDATA[23:0]),
        .wide(sz == cfd_pkg::SZ_WORD || sz == cfd_pkg::SZ_LONG || is_fetch),
        .data(result),
        .lane(REG_ADDR[1:0] - 2'b11 + REG_WDATA[1:0] + 2'b11),
        .aligned(aligned),
        .lane_byte(lane_byte)
    );

    // ==========================================
    // Datapath
    always_comb begin
        next_result = result;
        next_flags = flags;
        sum = 33'h0_0000_0000;
        sa = |(opa & sign_mask);
        sb = |(opb & sign_mask);
        sr = 1'b0;
        unique case (op)
            cfd_pkg::OP_ADD, cfd_pkg::OP_SUB: begin
                if (op == cfd_pkg::OP_ADD) begin
                    sum = {1'b0, opa & mask} + {1'b0, opb & mask};
                end else begin
                    sum = {1'b0, opa & mask} - {1'b0, opb & mask};
                end
                next_result = sum[31:0] & mask;
                sr = |(next_result & sign_mask);
                next_flags[cfd_pkg::FLAG_CARRY] = |((sum[32:0] & ~{1'b0, mask}) | {sum[32], 32'h0});
                if (op == cfd_pkg::OP_ADD) begin
                    next_flags[cfd_pkg::FLAG_OVERFLOW] = (sa == sb) && (sr != sa);
                end else begin
                    next_flags[cfd_pkg::FLAG_OVERFLOW] = (sa != sb) && (sr != sa);
                end
            end
            cfd_pkg::OP_SHL, cfd_pkg::OP_ROTL: begin
                next_result = ((opa << 1) | ((op == cfd_pkg::OP_ROTL) ? {31'h0, sa} : 32'h0)) & mask;
                next_flags[cfd_pkg::FLAG_CARRY] = sa;
                next_flags[cfd_pkg::FLAG_OVERFLOW] = 1'b0;
            end
            cfd_pkg::OP_SHR, cfd_pkg::OP_ROTR: begin
                next_result = ((opa & mask) >> 1) | ((op == cfd_pkg::OP_ROTR && opa[0]) ? sign_mask : 32'h0);
                next_flags[cfd_pkg::FLAG_CARRY] = opa[0];
                next_flags[cfd_pkg::FLAG_OVERFLOW] = 1'b0;
            end
            cfd_pkg::OP_BLD: next_flags[cfd_pkg::FLAG_CARRY] = opa[bitn];
            cfd_pkg::OP_BAND: next_flags[cfd_pkg::FLAG_CARRY] = acc_bit & opa[bitn];
            cfd_pkg::OP_BOR: next_flags[cfd_pkg::FLAG_CARRY] = acc_bit | opa[bitn];
            cfd_pkg::OP_BXOR: next_flags[cfd_pkg::FLAG_CARRY] = acc_bit ^ opa[bitn];
            cfd_pkg::OP_BST, cfd_pkg::OP_BSET, cfd_pkg::OP_BCLR: begin
                next_result = {24'h0, opa[7:0]};
                if (op == cfd_pkg::OP_BST) begin
                    next_result[bitn] = acc_bit;
                end else begin
                    next_result[bitn] = (op == cfd_pkg::OP_BSET);
                end
            end
            cfd_pkg::OP_DADD, cfd_pkg::OP_DSUB: begin
                next_result = {24'h0, bcd_val};
                next_flags[cfd_pkg::FLAG_CARRY] = bcd_c;
                sr = bcd_val[7];
            end
            cfd_pkg::OP_MOVE: begin
                next_result = opa & mask;
                sr = sa;
                next_flags[cfd_pkg::FLAG_OVERFLOW] = 1'b0;
            end
        endcase
        if (op != cfd_pkg::OP_BLD && op != cfd_pkg::OP_BAND && op != cfd_pkg::OP_BOR
            && op != cfd_pkg::OP_BXOR && op != cfd_pkg::OP_BST && op != cfd_pkg::OP_BSET
            && op != cfd_pkg::OP_BCLR) begin
            if (op != cfd_pkg::OP_ADD && op != cfd_pkg::OP_SUB && op != cfd_pkg::OP_DADD
                && op != cfd_pkg::OP_DSUB && op != cfd_pkg::OP_MOVE) begin
                sr = |(next_result & sign_mask);
            end
            next_flags[cfd_pkg::FLAG_SIGN] = sr;
            next_flags[cfd_pkg::FLAG_ZERO] = (next_result == 32'h0);
        end
    end

    // ==========================================
    // Registers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            flags <= cfd_pkg::FLAGS_RESET;
        end else if (REG_WR && REG_ADDR == cfd_pkg::OFS_FLAGS) begin
            flags <= REG_WDATA[7:0];
        end else if (cmd_go) begin
            flags <= next_flags;
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            opa <= 32'h0;
            opb <= 32'h0;
            result <= 32'h0;
        end else begin
            if (REG_WR && REG_ADDR == cfd_pkg::OFS_OPA) begin
                opa <= REG_WDATA;
            end
            if (REG_WR && REG_ADDR == cfd_pkg::OFS_OPB) begin
                opb <= REG_WDATA;
            end
            if (cmd_go) begin
                result <= next_result;
            end
        end
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            addr <= 24'h0;
        end else if (REG_WR && REG_ADDR == cfd_pkg::OFS_ADDR) begin
            addr <= aligned;
        end
    end

    // ==========================================
    // Read port
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            REG_RDATA <= 32'h0;
        end else if (REG_RD) begin
            unique case (REG_ADDR)
                cfd_pkg::OFS_FLAGS: REG_RDATA <= {24'h0, flags};
                cfd_pkg::OFS_OPA: REG_RDATA <= opa;
                cfd_pkg::OFS_OPB: REG_RDATA <= opb;
                cfd_pkg::OFS_RESULT: REG_RDATA <= result;
                cfd_pkg::OFS_ALIGNED: REG_RDATA <= {8'h0, addr};
                cfd_pkg::OFS_MEMDATA: REG_RDATA <= {result[31:24], result[23:16], result[15:8], result[7:0]};
                default: REG_RDATA <= 32'h0;
            endcase
        end else begin
            REG_RDATA <= 32'h0;
        end
    end
endmodule : cfd_core

// file: sim/cfd_core_assertions.sv
`timescale 1ns/1ps
// ==========================================
// Port checker
module cfd_core_checker (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic [3:0] REG_ADDR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_WR,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA
);
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);
    logic [31:0] last_addr;
    logic wide;
    logic rd_flags;
    logic rd_res;
    logic add_long;
    logic shift_cmd;
    // ==========================================
    // Helpers
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            last_addr <= 32'h0;
        end else if (REG_WR && REG_ADDR == cfd_pkg::OFS_ADDR) begin
            last_addr <= REG_WDATA;
        end
    end
    assign wide = last_addr[9] || last_addr[5:4] == cfd_pkg::SZ_WORD || last_addr[5:4] == cfd_pkg::SZ_LONG;
    assign rd_flags = REG_RD && REG_ADDR == cfd_pkg::OFS_FLAGS;
    assign rd_res = REG_RD && REG_ADDR == cfd_pkg::OFS_RESULT;
    assign add_long = REG_WR && REG_ADDR == cfd_pkg::OFS_CMD && REG_WDATA[5:0] == 6'h20;
    assign shift_cmd = REG_WR && REG_ADDR == cfd_pkg::OFS_CMD && REG_WDATA[3:1] == 3'h1;
    // ==========================================
    // Assertions
    rdata_idle_a: assert property (!$past(REG_RD) |-> REG_RDATA == 32'h0)
        else $error("read data not zero outside read answer");
    cmd_write_only_a: assert property (REG_RD && REG_ADDR == cfd_pkg::OFS_CMD |=> REG_RDATA == 32'h0)
        else $error("command register read not zero");
    unmapped_read_a: assert property (REG_RD && REG_ADDR > cfd_pkg::OFS_MEMDATA |=> REG_RDATA == 32'h0)
        else $error("unmapped read not zero");
    flag_readback_a: assert property (REG_WR && REG_ADDR == cfd_pkg::OFS_FLAGS ##1 rd_flags
        |=> REG_RDATA[7:0] == $past(REG_WDATA[7:0], 2)) else $error("flag write not read back");
    sign_flag_a: assert property (add_long ##1 rd_res ##1 rd_flags
        |=> REG_RDATA[cfd_pkg::FLAG_SIGN] == $past(REG_RDATA[31])) else $error("sign flag wrong");
    zero_flag_a: assert property (add_long ##1 rd_res ##1 rd_flags
        |=> REG_RDATA[cfd_pkg::FLAG_ZERO] == ($past(REG_RDATA) == 32'h0)) else $error("zero flag wrong");
    shift_ovf_a: assert property (shift_cmd ##1 rd_res ##1 rd_flags
        |=> !REG_RDATA[cfd_pkg::FLAG_OVERFLOW]) else $error("overflow not cleared by shift");
    even_addr_a: assert property (REG_RD && REG_ADDR == cfd_pkg::OFS_ALIGNED
        |=> REG_RDATA[23:0] == {last_addr[23:1], last_addr[0] && !wide}) else $error("aligned address wrong");
    cover property (add_long ##1 rd_res ##1 rd_flags);
    cover property (REG_RD && REG_ADDR == cfd_pkg::OFS_ALIGNED && wide);
    cover property (shift_cmd ##1 rd_res ##1 rd_flags);
endmodule : cfd_core_checker

bind cfd_core cfd_core_checker u_chk (.CLK(CLK), .SYS_RST(SYS_RST), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WR(REG_WR), .REG_RD(REG_RD), .REG_RDATA(REG_RDATA));

// file: sim/test_cfd_core.sv
`timescale 1ns/1ps
// ==========================================
// Self-checking bench
module test_cfd_core;
    typedef struct packed {
        logic [3:0] fin;
        logic [31:0] a;
        logic [7:0] b;
        logic [9:0] cmd;
        logic [31:0] res;
        logic chk;
        logic [3:0] fl;
    } cfd_row_t;
    localparam cfd_row_t rows [21] = '{
        '{4'h0, 32'h8, 8'h08, 10'h030, 32'h0, 1'b1, 4'h7},
        '{4'h0, 32'h7fffffff, 8'h01, 10'h020, 32'h80000000, 1'b1, 4'ha},
        '{4'h0, 32'hffffffff, 8'h01, 10'h020, 32'h0, 1'b1, 4'h5},
        '{4'h0, 32'h0, 8'h01, 10'h021, 32'hffffffff, 1'b1, 4'h9},
        '{4'h0, 32'h7fff, 8'h01, 10'h010, 32'h8000, 1'b1, 4'ha},
        '{4'h0, 32'h80, 8'h80, 10'h000, 32'h0, 1'b1, 4'h7},
        '{4'h2, 32'h80000001, 8'h01, 10'h022, 32'h2, 1'b1, 4'h1},
        '{4'h0, 32'h1, 8'h01, 10'h003, 32'h0, 1'b1, 4'h5},
        '{4'h0, 32'h81, 8'h01, 10'h004, 32'h3, 1'b1, 4'h1},
        '{4'h0, 32'h1, 8'h01, 10'h005, 32'h80, 1'b1, 4'h9},
        '{4'he, 32'h8, 8'h0, 10'h0c6, 32'h0, 1'b0, 4'hf},
        '{4'h1, 32'h55, 8'h0, 10'h1c7, 32'hd5, 1'b1, 4'h1},
        '{4'h1, 32'hfe, 8'h0, 10'h008, 32'h0, 1'b0, 4'h0},
        '{4'h0, 32'h2, 8'h0, 10'h049, 32'h0, 1'b0, 4'h1},
        '{4'h1, 32'h4, 8'h0, 10'h08a, 32'h0, 1'b0, 4'h0},
        '{4'he, 32'hf0, 8'h0, 10'h00e, 32'hf1, 1'b1, 4'he},
        '{4'h0, 32'hff, 8'h0, 10'h1cf, 32'h7f, 1'b1, 4'h0},
        '{4'h0, 32'h1a, 8'h0, 10'h00b, 32'h20, 1'b1, 4'h0},
        '{4'h0, 32'h9a, 8'h0, 10'h00b, 32'h0, 1'b1, 4'h5},
        '{4'h1, 32'h75, 8'h0, 10'h00c, 32'h15, 1'b1, 4'h1},
        '{4'h3, 32'h0, 8'h0, 10'h02d, 32'h0, 1'b1, 4'h5}
    };
    localparam logic [31:0] addrs [5] = '{32'h000011, 32'h123421, 32'h000201, 32'h000001, 32'h000031};
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [31:0] reg_wdata = 32'h0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [31:0] reg_rdata;
    logic [31:0] rd;
    logic [31:0] msk;
    int fails = 0;
    int samples_checked = 0;
    cfd_core u_dut (.CLK(clk), .SYS_RST(sys_rst), .REG_ADDR(reg_addr), .REG_WDATA(reg_wdata), .REG_WR(reg_wr),
        .REG_RD(reg_rd), .REG_RDATA(reg_rdata));
    always #12.5 clk = ~clk;
    // ==========================================
    // Tasks
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            fails++;
            $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask : check
    task automatic op(input logic w, input logic r, input logic [3:0] a, input logic [31:0] d);
        reg_wr <= w;
        reg_rd <= r;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
    endtask : op
    task automatic rdr(input logic [3:0] a);
        op(1'b0, 1'b1, a, 32'h0);
        #1 rd = reg_rdata;
    endtask : rdr
    function automatic logic [31:0] exp_aligned(input logic [31:0] d);
        logic w;
        w = d[9] || d[5:4] == 2'h1 || d[5:4] == 2'h2;
        return {8'h0, d[23:1], d[0] & ~w};
    endfunction : exp_aligned
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : print_verdict
    // ==========================================
    // Sequence
    initial begin
        repeat (3) @(posedge clk);
        sys_rst <= 1'b0;
        rdr(cfd_pkg::OFS_FLAGS);
        check(rd & 32'hff, {24'h0, cfd_pkg::FLAGS_RESET});
        rdr(cfd_pkg::OFS_RESULT);
        check(rd, 32'h0);
        for (int i = 0; i < 21; i++) begin
            op(1'b1, 1'b0, cfd_pkg::OFS_FLAGS, {28'h0, rows[i].fin});
            op(1'b1, 1'b0, cfd_pkg::OFS_OPA, rows[i].a);
            op(1'b1, 1'b0, cfd_pkg::OFS_OPB, {24'h0, rows[i].b});
            op(1'b1, 1'b0, cfd_pkg::OFS_CMD, {22'h0, rows[i].cmd});
            rdr(cfd_pkg::OFS_RESULT);
            msk = (rows[i].cmd[5:4] == 2'h0) ? 32'hff : (rows[i].cmd[5:4] == 2'h1) ? 32'hffff : 32'hffffffff;
            if (rows[i].chk) check(rd & msk, rows[i].res);
            rdr(cfd_pkg::OFS_FLAGS);
            check({28'h0, rd[3:0]}, {28'h0, rows[i].fl});
        end
        op(1'b1, 1'b0, cfd_pkg::OFS_FLAGS, 32'h5a);
        rdr(cfd_pkg::OFS_FLAGS);
        check(rd & 32'hff, 32'h5a);
        op(1'b1, 1'b0, cfd_pkg::OFS_OPA, 32'h11223344);
        op(1'b1, 1'b0, cfd_pkg::OFS_CMD, 32'h02d);
        rdr(cfd_pkg::OFS_MEMDATA);
        check(rd, 32'h11223344);
        rdr(4'hf);
        check(rd, 32'h0);
        rdr(cfd_pkg::OFS_CMD);
        check(rd, 32'h0);
        for (int i = 0; i < 5; i++) begin
            op(1'b1, 1'b0, cfd_pkg::OFS_ADDR, addrs[i]);
            rdr(cfd_pkg::OFS_ALIGNED);
            check(rd & 32'hffffff, exp_aligned(addrs[i]));
        end
        op(1'b0, 1'b0, 4'h0, 32'h0);
        sys_rst <= 1'b1;
        @(posedge clk);
        sys_rst <= 1'b0;
        rdr(cfd_pkg::OFS_FLAGS);
        check(rd & 32'hff, {24'h0, cfd_pkg::FLAGS_RESET});
        op(1'b0, 1'b0, 4'h0, 32'h0);
        print_verdict();
    end
    initial begin
        repeat (5000) @(posedge clk);
        fails++;
        print_verdict();
    end
endmodule : test_cfd_core
